/* File: rtl/lbp_pkg.sv */
// Purpose: shared constants and types for the local bus host port
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: both ends meet in lbp_if
// Notes on behaviour
// - address and data share one 32-bit bus
// - host drives four active-low byte lane selects
// - space select low for I/O, high memory
// - direction low for read, high write
// - host pulses cycle start with address valid
// - device samples and drives on bus clock
// - ready return low extends read, data held
// - claim output low for own address window
// - device pulses ready low to end cycle
// - reset high holds device in reset state
// - data buffer enable low during data phase
// - address buffer enable low during address phase
// - turnaround low on writes, high on reads
// - interrupt low while condition pending, open collector
package lbp_pkg;
  localparam int DATA_W = 32; // shared bus width
  localparam int LANES = 4; // byte lanes
  localparam logic SPACE_IO = 1'h0; // space select value for I/O
  localparam logic SPACE_MEM = 1'h1; // space select value for memory
  localparam logic DIR_READ = 1'h0; // direction value for read
  localparam logic DIR_WRITE = 1'h1; // direction value for write
  localparam logic [31:0] MEM_BASE = 32'h000a_0000; // memory window base
  localparam logic [31:0] MEM_MASK = 32'hfffe_0000; // memory window mask
  localparam logic [31:0] IO_BASE = 32'h0000_03c0; // I/O window base
  localparam logic [31:0] IO_MASK = 32'hffff_ffe0; // I/O window mask
  localparam int WAIT_CYC = 1; // device wait cycles before ready
  typedef enum logic [2:0] {
    LBP_IDLE = 3'h0, // waiting for cycle start
    LBP_ADDR = 3'h1, // address phase, decode
    LBP_DATA = 3'h2, // data phase, wait states
    LBP_DONE = 3'h3, // ready driven
    LBP_HOLD = 3'h4 // read data held for ready return
  } lbp_state_t;
endpackage

/* File: rtl/lbp_if.sv */
// Purpose: wires between host and device ends of the local bus
// Assumes: testbench resolves shared bus from output enables
// Notes: ad_bus is the resolved level of the shared bus
`timescale 1ns/1ps
interface lbp_if;
  logic [31:0] host_ad_o; // host address/data drive
  logic host_ad_oe; // host drives bus
  logic [31:0] dev_ad_o; // device read data drive
  logic dev_ad_oe; // device drives bus
  logic [31:0] ad_bus; // resolved bus level
  logic [3:0] lane_select_n; // lane3..lane0 selects, low valid
  logic space_select; // low I/O, high memory
  logic cycle_dir; // low read, high write
  logic cycle_start_strobe_n; // low: address valid
  logic ready_return_n; // low: extend read
  logic local_claim_n; // low: device claims cycle
  logic ready_n_o; // device ready drive value
  logic ready_n_oe; // device drives ready
  logic data_buffer_enable_n; // low: data transceiver on
  logic addr_buffer_enable_n; // low: address buffer on
  logic buf_dir; // low write, high read
  logic irq_n_o; // interrupt drive value
  logic irq_n_oe; // interrupt driven
  modport host (
    output host_ad_o, host_ad_oe, lane_select_n, space_select, cycle_dir,
    output cycle_start_strobe_n, ready_return_n,
    input ad_bus, local_claim_n, ready_n_o, ready_n_oe, irq_n_o, irq_n_oe
  );
  modport device (
    output dev_ad_o, dev_ad_oe, local_claim_n, ready_n_o, ready_n_oe,
    output data_buffer_enable_n, addr_buffer_enable_n, buf_dir, irq_n_o, irq_n_oe,
    input ad_bus, lane_select_n, space_select, cycle_dir, cycle_start_strobe_n,
    input ready_return_n
  );
endinterface

/* File: rtl/lbp_device.sv */
// Purpose: device end of the local bus host port
// Assumes: bus inputs synchronous to clk, the local bus clock
// Notes: internal side sees one access per claimed cycle
`timescale 1ns/1ps
module lbp_device (
  input wire logic clk, // local bus clock
  input wire logic reset, // synchronous reset, high
  lbp_if.device bus, // host bus side
  output logic acc_valid, // one-cycle pulse: access served
  output logic acc_write, // access was a write
  output logic acc_mem, // access was memory space
  output logic [31:0] acc_addr, // access address
  output logic [31:0] acc_wdata, // write data
  output logic [3:0] acc_lanes_n, // lane selects of the access
  input wire logic [31:0] rd_data, // read data for current address
  input wire logic irq_pending // interrupting condition present
);
  lbp_pkg::lbp_state_t state_ff; // cycle state
  lbp_pkg::lbp_state_t nxt_state;
  logic [31:0] addr_ff; // latched address
  logic [31:0] rdata_ff; // latched read data
  logic write_ff; // latched direction
  logic mem_ff; // latched space
  logic [3:0] lanes_ff; // latched lane selects
  logic [1:0] wait_ff; // wait-state counter
  logic hit; // address falls in own window
  logic hit_mem; // address inside the memory window
  logic hit_io; // address inside the i/o window
  logic wait_done; // last wait state reached
  logic in_addr; // address phase of a claimed cycle
  logic in_data; // data phase, wait states included
  logic in_done; // ready cycle
  logic in_hold; // read data held for ready return
  logic busy; // any claimed state
  logic rd_drive; // read data on the shared bus

  // memory window compare on the live bus
  always_comb begin
    hit_mem = (bus.ad_bus & lbp_pkg::MEM_MASK) == lbp_pkg::MEM_BASE;
  end

  // i/o window compare on the live bus
  always_comb begin
    hit_io = (bus.ad_bus & lbp_pkg::IO_MASK) == lbp_pkg::IO_BASE;
  end

  // pick the window that the space select names
  always_comb begin
    if (bus.space_select == lbp_pkg::SPACE_MEM) begin
      hit = hit_mem; // memory cycle
    end else begin
      hit = hit_io; // i/o cycle
    end
  end

  // one flag per busy state, so the pin logic reads plainly
  always_comb begin
    in_addr = state_ff == lbp_pkg::LBP_ADDR;
    in_data = state_ff == lbp_pkg::LBP_DATA;
    in_done = state_ff == lbp_pkg::LBP_DONE;
    in_hold = state_ff == lbp_pkg::LBP_HOLD;
  end

  // claimed from the address phase until the cycle is let go
  always_comb begin
    busy = in_addr || in_data || in_done || in_hold;
  end

  // read data stands from the first data cycle until release
  always_comb begin
    rd_drive = !write_ff && (in_data || in_done || in_hold);
  end

  // wait states used up, data phase may end
  always_comb begin
    wait_done = wait_ff == 2'(lbp_pkg::WAIT_CYC);
  end

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lbp_pkg::LBP_IDLE: begin
        if (!bus.cycle_start_strobe_n && hit) begin
          nxt_state = lbp_pkg::LBP_ADDR;
        end
      end
      lbp_pkg::LBP_ADDR: nxt_state = lbp_pkg::LBP_DATA;
      lbp_pkg::LBP_DATA: begin
        if (wait_done) begin
          nxt_state = lbp_pkg::LBP_DONE;
        end
      end
      lbp_pkg::LBP_DONE: begin
        if (!write_ff && !bus.ready_return_n) begin
          nxt_state = lbp_pkg::LBP_HOLD;
        end else begin
          nxt_state = lbp_pkg::LBP_IDLE;
        end
      end
      lbp_pkg::LBP_HOLD: begin
        if (bus.ready_return_n) begin
          nxt_state = lbp_pkg::LBP_IDLE;
        end
      end
      default: nxt_state = lbp_pkg::LBP_IDLE;
    endcase
  end

  // state register, held idle in reset
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= lbp_pkg::LBP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // capture address and status at cycle start
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_ff <= 32'h0;
      write_ff <= 1'h0;
      mem_ff <= 1'h0;
      lanes_ff <= 4'hf;
    end else if (state_ff == lbp_pkg::LBP_IDLE && !bus.cycle_start_strobe_n) begin
      addr_ff <= bus.ad_bus;
      write_ff <= bus.cycle_dir == lbp_pkg::DIR_WRITE;
      mem_ff <= bus.space_select == lbp_pkg::SPACE_MEM;
      lanes_ff <= bus.lane_select_n;
    end
  end

  // wait-state counter in data phase
  always_ff @(posedge clk) begin
    if (reset || state_ff != lbp_pkg::LBP_DATA) begin
      wait_ff <= 2'h0;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end

  // read data latched once, held through extension
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 32'h0;
    end else if (state_ff == lbp_pkg::LBP_ADDR) begin
      rdata_ff <= rd_data;
    end
  end

  // internal access pulse, write data taken at ready
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_valid <= 1'h0;
      acc_write <= 1'h0;
      acc_mem <= 1'h0;
      acc_addr <= 32'h0;
      acc_wdata <= 32'h0;
      acc_lanes_n <= 4'hf;
    end else begin
      acc_valid <= state_ff == lbp_pkg::LBP_DONE;
      if (state_ff == lbp_pkg::LBP_DONE) begin
        acc_write <= write_ff;
        acc_mem <= mem_ff;
        acc_addr <= addr_ff;
        acc_wdata <= write_ff ? bus.ad_bus : 32'h0;
        acc_lanes_n <= lanes_ff;
      end
    end
  end

  // claim pin, low while a claimed cycle runs
  always_comb begin
    bus.local_claim_n = !busy;
  end

  // ready pin, open collector: pulled low for the single done cycle
  always_comb begin
    bus.ready_n_o = 1'h0; // only ever drives low
    bus.ready_n_oe = in_done;
  end

  // transceiver enables, never both on at once
  always_comb begin
    bus.addr_buffer_enable_n = !in_addr;
    bus.data_buffer_enable_n = !(in_data || in_done || in_hold);
  end

  // transceiver direction follows the latched cycle direction
  always_comb begin
    if (write_ff) begin
      bus.buf_dir = 1'h0; // write: host towards device
    end else begin
      bus.buf_dir = 1'h1; // read: device towards host
    end
  end

  // read data from a flop, so it stays put through any extension
  always_comb begin
    bus.dev_ad_o = rdata_ff;
    bus.dev_ad_oe = rd_drive;
  end

  // interrupt pin, open collector, released while in reset
  always_comb begin
    bus.irq_n_o = 1'h0; // only ever drives low
    bus.irq_n_oe = irq_pending && !reset;
  end
endmodule

/* File: rtl/lbp_host.sv */
// Purpose: host end of the local bus host port
// Assumes: user side holds request until req_ack
// Notes: claim sampled one edge after cycle start; no claim ends cycle
`timescale 1ns/1ps
module lbp_host (
  input wire logic clk, // local bus clock
  input wire logic reset, // synchronous reset, high
  lbp_if.host bus, // device side
  input wire logic req_valid, // request present
  input wire logic req_write, // request is a write
  input wire logic req_mem, // memory space when high
  input wire logic [31:0] req_addr, // address
  input wire logic [31:0] req_wdata, // write data
  input wire logic [3:0] req_lanes_n, // lane selects, low valid
  input wire logic [1:0] req_hold, // extra cycles to extend reads
  output logic req_ack, // one-cycle pulse: request done
  output logic req_claimed, // device claimed the cycle
  output logic [31:0] resp_rdata, // read data
  output logic irq_seen // device interrupt level
);
  typedef enum logic [1:0] {
    LBH_IDLE = 2'h0, LBH_ADDR = 2'h1, LBH_DATA = 2'h2, LBH_HOLD = 2'h3
  } lbp_host_state_t;
  lbp_host_state_t state_ff; // bus cycle state
  logic [1:0] hold_ff; // extension counter
  logic ready_seen; // ready low on bus

  assign ready_seen = bus.ready_n_oe && !bus.ready_n_o;

  // cycle sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= LBH_IDLE;
      hold_ff <= 2'h0;
    end else begin
      case (state_ff)
        LBH_IDLE: if (req_valid && !req_ack) state_ff <= LBH_ADDR;
        LBH_ADDR: state_ff <= LBH_DATA;
        LBH_DATA: begin
          if (ready_seen) begin
            hold_ff <= req_hold;
            state_ff <= (!req_write && req_hold != 2'h0) ? LBH_HOLD : LBH_IDLE;
          end else if (bus.local_claim_n) begin
            state_ff <= LBH_IDLE; // unclaimed, give up
          end
        end
        LBH_HOLD: begin
          hold_ff <= hold_ff - 2'h1;
          if (hold_ff == 2'h1) state_ff <= LBH_IDLE;
        end
        default: state_ff <= LBH_IDLE;
      endcase
    end
  end

  // answers to the user side
  always_ff @(posedge clk) begin
    if (reset) begin
      req_ack <= 1'h0;
      req_claimed <= 1'h0;
      resp_rdata <= 32'h0;
      irq_seen <= 1'h0;
    end else begin
      irq_seen <= bus.irq_n_oe && !bus.irq_n_o;
      req_ack <= state_ff == LBH_DATA && (ready_seen || bus.local_claim_n);
      if (state_ff == LBH_DATA) begin
        req_claimed <= ready_seen;
        if (ready_seen && !req_write) resp_rdata <= bus.ad_bus;
      end
    end
  end

  // pin drive
  always_comb begin
    bus.cycle_start_strobe_n = !(state_ff == LBH_ADDR);
    bus.host_ad_o = (state_ff == LBH_ADDR) ? req_addr : req_wdata;
    bus.host_ad_oe = state_ff == LBH_ADDR || (state_ff == LBH_DATA && req_write);
    bus.lane_select_n = state_ff == LBH_IDLE ? 4'hf : req_lanes_n;
    bus.space_select = req_mem ? lbp_pkg::SPACE_MEM : lbp_pkg::SPACE_IO;
    bus.cycle_dir = req_write ? lbp_pkg::DIR_WRITE : lbp_pkg::DIR_READ;
    bus.ready_return_n = !(state_ff == LBH_DATA && ready_seen && !req_write &&
                           req_hold != 2'h0 || state_ff == LBH_HOLD &&
                           hold_ff != 2'h1);
  end
endmodule

/* File: testbench/lbp_monitor.sv */
// Purpose: assertions on the wires between host and device ends
// Assumes: one clock, synchronous active-high reset
// Notes: instantiated beside the interface, no bind
`timescale 1ns/1ps
module lbp_monitor (
  input wire logic clk, // bus clock
  input wire logic reset, // sync reset, high
  input wire logic [31:0] ad_bus, // resolved bus
  input wire logic space_select, // low i/o
  input wire logic cycle_start_strobe_n, // address valid, low
  input wire logic ready_return_n, // extend read, low
  input wire logic local_claim_n, // claim, low
  input wire logic ready_n_o, // ready drive value
  input wire logic ready_n_oe, // ready driven
  input wire logic [31:0] dev_ad_o, // device read data
  input wire logic dev_ad_oe, // device drives bus
  input wire logic data_buffer_enable_n, // data buffer on, low
  input wire logic addr_buffer_enable_n, // address buffer on, low
  input wire logic buf_dir, // low write, high read
  input wire logic irq_n_o, // interrupt drive value
  input wire logic irq_n_oe // interrupt driven
);
  logic hit; // address phase falls in a window
  // window decode, independent of the device body
  assign hit = space_select ? ((ad_bus & lbp_pkg::MEM_MASK) == lbp_pkg::MEM_BASE)
    : ((ad_bus & lbp_pkg::IO_MASK) == lbp_pkg::IO_BASE);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_claim; !cycle_start_strobe_n && local_claim_n |=> local_claim_n != $past(hit);
  endproperty
  a_claim: assert property (p_claim) else $error("claim does not follow window");
  property p_rdy_len; ready_n_oe |=> !ready_n_oe; endproperty
  a_rdy_len: assert property (p_rdy_len) else $error("ready longer than one cycle");
  property p_rdy_own; ready_n_oe |-> !ready_n_o && !local_claim_n; endproperty
  a_rdy_own: assert property (p_rdy_own) else $error("ready outside claimed cycle");
  property p_rdy_time; !cycle_start_strobe_n ##1 !local_claim_n |-> ##[2:3] ready_n_oe;
  endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("claimed cycle not ended");
  property p_excl; addr_buffer_enable_n || data_buffer_enable_n; endproperty
  a_excl: assert property (p_excl) else $error("both buffers enabled");
  property p_addr_buf; $fell(local_claim_n) |-> !addr_buffer_enable_n; endproperty
  a_addr_buf: assert property (p_addr_buf) else $error("address buffer off");
  property p_data_buf; dev_ad_oe |-> !data_buffer_enable_n && buf_dir; endproperty
  a_data_buf: assert property (p_data_buf) else $error("read data path wrong");
  property p_dir_wr; !data_buffer_enable_n && !dev_ad_oe |-> !buf_dir; endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("write direction wrong");
  property p_hold; !ready_return_n && dev_ad_oe |=> dev_ad_oe && $stable(dev_ad_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data dropped early");
  property p_irq; irq_n_oe |-> !irq_n_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt driven high");
  property p_rst; disable iff (1'b0) reset |=> local_claim_n && addr_buffer_enable_n
    && data_buffer_enable_n && !dev_ad_oe && !ready_n_oe; endproperty
  a_rst: assert property (p_rst) else $error("outputs active in reset");
endmodule

/* File: testbench/local_bus_host_port_test.sv */
// Purpose: self-checking bench joining host and device ends
// Assumes: 40 MHz clock, inputs driven 1 ns after the rising edge
// Notes: device read data is the address xor a fixed pattern
`timescale 1ns/1ps
module local_bus_host_port_test;
  localparam logic [31:0] PAT = 32'h5a5a_5a5a; // read data pattern
  logic clk = 1'b0; // bus clock
  logic reset = 1'b1; // sync reset
  logic req_valid = 1'b0; // request strobe
  logic req_write = 1'b0; // write request
  logic req_mem = 1'b0; // memory space
  logic [31:0] req_addr = 32'h0; // address
  logic [31:0] req_wdata = 32'h0; // write data
  logic [3:0] req_lanes_n = 4'hf; // lane selects
  logic [1:0] req_hold = 2'h0; // read extension
  logic irq_pending = 1'b0; // interrupt source
  logic req_ack, req_claimed, irq_seen, acc_valid, acc_write, acc_mem; // status
  logic [31:0] resp_rdata, acc_addr, acc_wdata, rd_data; // data words
  logic [3:0] acc_lanes_n; // lanes seen by device
  logic [69:0] cap; // last access seen by device
  int n_acc = 0, error_cnt = 0, n_compared = 0, cycles = 0; // counters
  lbp_if bus_if();
  // shared bus resolution, pull-ups when nobody drives
  assign bus_if.ad_bus = bus_if.dev_ad_oe ? bus_if.dev_ad_o
    : (bus_if.host_ad_oe ? bus_if.host_ad_o : 32'hffff_ffff);
  // the device samples read data during its address phase, when nobody drives the bus;
  // the request address is held until acknowledge, so it names the word instead
  assign rd_data = req_addr ^ PAT;
  lbp_host lbp_host_inst (.clk, .reset, .bus(bus_if), .req_valid, .req_write, .req_mem,
    .req_addr, .req_wdata, .req_lanes_n, .req_hold, .req_ack, .req_claimed, .resp_rdata,
    .irq_seen);
  lbp_device lbp_device_inst (.clk, .reset, .bus(bus_if), .acc_valid, .acc_write, .acc_mem,
    .acc_addr, .acc_wdata, .acc_lanes_n, .rd_data, .irq_pending);
  lbp_monitor lbp_monitor_inst (.clk, .reset, .ad_bus(bus_if.ad_bus),
    .space_select(bus_if.space_select), .cycle_start_strobe_n(bus_if.cycle_start_strobe_n),
    .ready_return_n(bus_if.ready_return_n), .local_claim_n(bus_if.local_claim_n),
    .ready_n_o(bus_if.ready_n_o), .ready_n_oe(bus_if.ready_n_oe), .dev_ad_o(bus_if.dev_ad_o),
    .dev_ad_oe(bus_if.dev_ad_oe), .data_buffer_enable_n(bus_if.data_buffer_enable_n),
    .addr_buffer_enable_n(bus_if.addr_buffer_enable_n), .buf_dir(bus_if.buf_dir),
    .irq_n_o(bus_if.irq_n_o), .irq_n_oe(bus_if.irq_n_oe));
  always #12.5 clk = ~clk;
  // capture each served access; count cycles against a hang
  always @(posedge clk) begin
    if (acc_valid === 1'b1) begin
      cap <= {acc_write, acc_mem, acc_lanes_n, acc_addr, acc_wdata};
      n_acc <= n_acc + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic compare(input logic [69:0] exp, input logic [69:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // one host request, held until acknowledged, then settle
  task automatic access(input logic w, input logic m, input logic [31:0] a,
      input logic [31:0] d, input logic [3:0] ln, input logic [1:0] h);
    int n;
    n = 0;
    @(posedge clk);
    #1 req_valid = 1'b1;
    req_write = w;
    req_mem = m;
    req_addr = a;
    req_wdata = d;
    req_lanes_n = ln;
    req_hold = h;
    do begin
      @(posedge clk);
      #1 n++;
    end while (req_ack !== 1'b1 && n < 40);
    if (n >= 40) error_cnt++;
    req_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    logic [31:0] a;
    int n0;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    // each single lane and both spaces: write, then read back with 0 to 3 cycles of extension
    for (int i = 0; i < 4; i++) begin
      a = i[0] ? lbp_pkg::IO_BASE + 32'(i * 4) : lbp_pkg::MEM_BASE + 32'(i * 4);
      access(1'b1, !i[0], a, 32'hc0de_0000 | a, 4'hf ^ (4'h1 << i), 2'h0);
      compare({1'b1, !i[0], 4'hf ^ (4'h1 << i), a, 32'hc0de_0000 | a}, cap);
      compare(70'(1), 70'(req_claimed));
      access(1'b0, !i[0], a, 32'h0, 4'h0, 2'(i));
      compare(70'(a ^ PAT), 70'(resp_rdata));
    end
    $display("test lanes and spaces done");
    // just past the i/o window and well below the memory window: not claimed, device sees nothing
    for (int j = 0; j < 2; j++) begin
      n0 = n_acc;
      access(j[0], j[0], j[0] ? 32'h0001_0000 : 32'h0000_03e0, 32'h1234_5678, 4'h0, 2'h0);
      compare(70'(0), 70'(req_claimed));
      compare(70'(n0), 70'(n_acc));
    end
    $display("test unclaimed done");
    irq_pending = 1'b1;
    repeat (3) @(posedge clk);
    #1 compare(70'(1), 70'(irq_seen));
    irq_pending = 1'b0;
    repeat (3) @(posedge clk);
    #1 compare(70'(0), 70'(irq_seen));
    $display("test interrupt done");
    print_verdict();
  end
endmodule
